/* dv/iron_safety_timeout_controller_bench.sv */
// self-checking bench for the iron safety timeout controller
// assumes ist_pkg, ist_timeout_ctrl and ist_far_side are compiled before it
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module iron_safety_timeout_controller_bench;
   import ist_pkg::*;
   localparam int HZ = 10; // slow mains variant keeps every count short
   localparam int DEB = 8;
   localparam int FAST = 20;
   localparam int SLOW = 1000; // on-half must outlast two tone halves
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic tilt_level = 1'b1;
   logic tilt_glitch = 1'b0;
   logic test_n_in = 1'b1;
   logic discharge_req_in = 1'b0;
   logic [15:0] mains_half = 16'(FAST);
   logic tilt_sensor_in, mains_timebase_in, relay_out, led_out, led_oe, led_lit;
   logic discharge_buzzer_out, cur;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d;
   int failures = 0, n_tests = 0, nm, nc;
   ////////////////////////////////////////////////////////////////////////////////
   // 25 MHz core clock
   always #20 core_clk = ~core_clk;
   ist_timeout_ctrl #(.MAINS_HZ(HZ), .VERT_MIN(10), .BUZZ_CONTINUAL(1'b0), .DEBOUNCE_CYC(DEB))
   ist_timeout_ctrl_inst
   (
      .core_clk(core_clk), .rst(rst), .tilt_sensor_in(tilt_sensor_in),
      .mains_timebase_in(mains_timebase_in), .test_n_in(test_n_in),
      .discharge_req_in(discharge_req_in), .relay_out(relay_out), .led_out(led_out),
      .led_oe(led_oe), .discharge_buzzer_out(discharge_buzzer_out),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );
   ist_far_side ist_far_side_inst
   (
      .core_clk(core_clk), .mains_half(mains_half), .tilt_level(tilt_level),
      .tilt_glitch(tilt_glitch), .led_out(led_out), .led_oe(led_oe),
      .tilt_sensor_in(tilt_sensor_in), .mains_timebase_in(mains_timebase_in),
      .led_lit(led_lit)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run, also reached from any exhausted wait
   task automatic stop_test;
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic fail_wait;
      failures++;
      stop_test();
   endtask : fail_wait
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   // write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] dd, input logic [1:0] er);
      int k;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (k == 50) fail_wait();
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] dd, output logic [1:0] rr);
      int k;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (k == 50) fail_wait();
      dd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // waits for relay (0), lit led (1) or buzzer (2); counts mains rises and cycles
   task automatic wait_for(input int sel, input logic v, output int m, output int c);
      logic prev;
      logic s;
      prev = mains_timebase_in;
      m = 0;
      for (c = 0; c < 60000; c++)
      begin
         s = (sel == 0) ? relay_out : (sel == 1) ? led_lit : discharge_buzzer_out;
         if (s === v) break;
         @(posedge core_clk);
         if (mains_timebase_in && !prev) m++;
         prev = mains_timebase_in;
      end
      if (c == 60000) fail_wait();
   endtask : wait_for
   // move to a position, then time the stay until the relay drops
   task automatic run_case(input logic lvl, input int ds);
      int lim;
      lim = ds * HZ / 10;
      @(posedge core_clk);
      tilt_level <= lvl;
      wait_for(0, 1'b1, nm, nc);
      `CHK(nc <= DEB + 12, 1'b1)
      `CHK(led_lit, 1'b1)
      wait_for(0, 1'b0, nm, nc);
      `CHK(nm >= lim - 1 && nm <= lim + 1, 1'b1)
      axi_rd(IST_OFS_STATUS, d, r);
      `CHK(d[IST_STAT_HORIZ_BIT], lvl)
      `CHK({r, d[2:0]}, {IST_RESP_OKAY, 3'b100})
      $display("test position %0d limit %0d done", lvl, lim);
   endtask : run_case
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      nc = $urandom(32'he7b67abd);
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      cyc(2);
      `CHK(relay_out, 1'b0)
      `CHK(led_lit, 1'b1)
      axi_rd(IST_OFS_STATUS, d, r);
      `CHK(d[2:0], 3'b001)
      // bounce shorter than the filter while parked is not movement
      repeat (4)
      begin
         @(posedge core_clk);
         tilt_glitch <= 1'b1;
         cyc($urandom_range(DEB - 3, 1));
         tilt_glitch <= 1'b0;
         cyc(DEB + 8);
      end
      `CHK(relay_out, 1'b0)
      axi_rd($urandom_range(1, 0) ? 4'hc : 4'h8, d, r);
      `CHK({r, d}, {IST_RESP_SLVERR, 32'h0})
      axi_wr(4'h8, 32'h3, IST_RESP_SLVERR);
      axi_wr(IST_OFS_STATUS, 32'hffffffff, IST_RESP_OKAY);
      axi_rd(IST_OFS_CTRL, d, r);
      `CHK(d[1:0], IST_CTRL_RESET)
      // outside a timeout the shared pin follows the discharge request
      repeat (4)
      begin
         @(posedge core_clk);
         discharge_req_in <= ($urandom_range(1, 0) != 0);
         cyc(6);
         `CHK(discharge_buzzer_out, discharge_req_in)
      end
      discharge_req_in <= 1'b0;
      test_n_in <= 1'b0;
      run_case(1'b0, 96);
      run_case(1'b1, 30);
      wait_for(1, 1'b0, nm, nc);
      wait_for(1, 1'b1, nm, nc);
      `CHK(nm >= HZ / 2 - 1 && nm <= HZ / 2 + 1, 1'b1)
      wait_for(1, 1'b0, nm, nc);
      `CHK(nm >= HZ / 2 - 1 && nm <= HZ / 2 + 1, 1'b1)
      mains_half <= 16'(SLOW);
      wait_for(1, 1'b1, nm, nc);
      cur = discharge_buzzer_out;
      wait_for(2, ~cur, nm, nc);
      wait_for(2, cur, nm, nc);
      `CHK(nc >= IST_CORE_HZ / 8000 - 2 && nc <= IST_CORE_HZ / 8000 + 2, 1'b1)
      wait_for(1, 1'b0, nm, nc);
      cyc(20);
      `CHK(discharge_buzzer_out, 1'b0)
      // mute bit silences the first 6400 cycles of a slow on-half that would otherwise carry the tone
      axi_wr(IST_OFS_CTRL, 32'h2, IST_RESP_OKAY);
      wait_for(1, 1'b1, nm, nc);
      nm = 0;
      repeat (6400)
      begin
         @(posedge core_clk);
         if (discharge_buzzer_out !== 1'b0) nm++;
      end
      `CHK(nm, 0)
      axi_wr(IST_OFS_CTRL, 32'h0, IST_RESP_OKAY);
      $display("test flash and tone done");
      mains_half <= 16'(FAST);
      cyc(16 * HZ * 2 * FAST);
      axi_rd(IST_OFS_STATUS, d, r);
      `CHK(d[IST_STAT_BURST_LSB +: 3], 3'h6)
      repeat (8)
      begin
         cyc(HZ * FAST / 2);
         `CHK(discharge_buzzer_out, 1'b0)
      end
      $display("test burst limit done");
      test_n_in <= 1'b1;
      axi_wr(IST_OFS_CTRL, 32'h1, IST_RESP_OKAY);
      run_case(1'b0, 96);
      axi_wr(IST_OFS_CTRL, 32'h0, IST_RESP_OKAY);
      run_case(1'b1, 300);
      stop_test();
   end
endmodule : iron_safety_timeout_controller_bench

/* dv/ist_far_side.sv */
// far side of the iron controller: tilt switch, mains line and led pin
// assumes the bench sets the mains half period, in core cycles, and the switch level
`timescale 1ns/10ps
module ist_far_side
(
   input wire logic core_clk,
   input wire logic [15:0] mains_half,
   input wire logic tilt_level,
   input wire logic tilt_glitch,
   input wire logic led_out,
   input wire logic led_oe,
   output logic tilt_sensor_in,
   output logic mains_timebase_in,
   output logic led_lit
);
   logic [15:0] cnt_reg = 16'h0;
   logic mains_reg = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // contact bounce rides on top of the resting switch level
   assign tilt_sensor_in = tilt_level ^ tilt_glitch;
   // led sits across the open drain, so a released pin leaves it lit
   assign led_lit = ~(led_oe & ~led_out);
   // mains runs free, through reset too, like the real line
   assign mains_timebase_in = mains_reg;
   always @(posedge core_clk)
   begin
      if (cnt_reg + 16'h1 >= mains_half)
      begin
         cnt_reg <= 16'h0;
         mains_reg <= ~mains_reg;
      end
      else
         cnt_reg <= cnt_reg + 16'h1;
   end
endmodule : ist_far_side

/* src/ist_pkg.sv */
// constants, state codes and helpers for the iron safety timeout controller
// assumes a 25 MHz core clock and an aligned 32-bit AXI4-Lite register port
package ist_pkg;
   // register byte offsets
   localparam logic [3:0] IST_OFS_CTRL = 4'h0;
   localparam logic [3:0] IST_OFS_STATUS = 4'h4;
   // control field positions and value after reset
   localparam int IST_CTRL_TEST_BIT = 0;
   localparam int IST_CTRL_MUTE_BIT = 1;
   localparam logic [1:0] IST_CTRL_RESET = 2'h0;
   // status field positions
   localparam int IST_STAT_STATE_LSB = 0;
   localparam int IST_STAT_HORIZ_BIT = 3;
   localparam int IST_STAT_TEST_BIT = 4;
   localparam int IST_STAT_RELAY_BIT = 5;
   localparam int IST_STAT_BURST_LSB = 6;
   localparam int IST_STAT_TIMER_LSB = 12;
   // axi responses
   localparam logic [1:0] IST_RESP_OKAY = 2'h0;
   localparam logic [1:0] IST_RESP_SLVERR = 2'h2;
   // clock and tone timing
   localparam int IST_CORE_HZ = 25_000_000;
   localparam int IST_TONE_HZ = 4000;
   localparam int IST_TONE_HALF_CYC = IST_CORE_HZ / (2 * IST_TONE_HZ);
   localparam int IST_DEBOUNCE_MS = 20;
   localparam int IST_DEBOUNCE_CYC = (IST_CORE_HZ / 1000) * IST_DEBOUNCE_MS;
   // timeouts in tenths of a second, real and test
   localparam int IST_HORIZ_DS = 300;
   localparam int IST_HORIZ_TEST_DS = 30;
   localparam int IST_VERT_DS_PER_MIN = 600;
   localparam int IST_VERT_TEST_DS = 96;
   localparam int IST_VERT15_TEST_DS = 120;
   localparam int IST_BURST_COUNT = 6;
   localparam int IST_TIMER_W = 20;

   typedef enum logic [2:0]
   {
      IST_ST_WAIT = 3'b001,
      IST_ST_HEAT = 3'b010,
      IST_ST_TOUT = 3'b100
   } ist_state_t;

   // mains cycles in a span given in tenths of a second
   function automatic logic [IST_TIMER_W-1:0] ist_limit_cycles(input int ds, input int hz);
      int prod;
      prod = (ds * hz) / 10;
      return prod[IST_TIMER_W-1:0];
   endfunction : ist_limit_cycles
endpackage : ist_pkg

/* src/ist_timeout_ctrl.sv */
// safety timeout controller for a clothes iron, with AXI4-Lite status/control
// assumes tilt, test, mains and discharge inputs are asynchronous pins
// Functional notes
// - relay output high lets the iron heat, low stops heating.
// - tilt input high means horizontal, low means vertical.
// - tilt input is debounced so bounce and vibration are ignored.
// - mains cycles are the time base; 50 or 60 Hz fixed per variant.
// - static horizontal beyond 30 s drops the relay.
// - static vertical beyond 8, 10 or 15 min drops the relay.
// - test input low shortens limits to 3 s, 9.6 s, 9.6 s, 12 s.
// - after reset relay stays off and LED on until first movement.
// - LED output released at power-on and while heating; pulling low turns LED off.
// - after timeout the LED flashes at about 1 Hz.
// - after timeout the buzzer plays 4 kHz in 0.5 s bursts.
// - bursts stop after 6 or continue, as the variant fixes.
// - shared output gives tone only after timeout, discharge otherwise.
`timescale 1ns/10ps
module ist_timeout_ctrl
#(
   parameter int MAINS_HZ = 50,
   parameter int VERT_MIN = 10,
   parameter bit BUZZ_CONTINUAL = 1'b1,
   parameter int DEBOUNCE_CYC = ist_pkg::IST_DEBOUNCE_CYC
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tilt_sensor_in,
   input wire logic mains_timebase_in,
   input wire logic test_n_in,
   input wire logic discharge_req_in,
   output logic relay_out,
   output logic led_out,
   output logic led_oe,
   output logic discharge_buzzer_out,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ist_pkg::*;
   localparam int HALF_SEC = MAINS_HZ / 2;
   localparam logic [IST_TIMER_W-1:0] LIM_H = ist_limit_cycles(IST_HORIZ_DS, MAINS_HZ);
   localparam logic [IST_TIMER_W-1:0] LIM_H_T = ist_limit_cycles(IST_HORIZ_TEST_DS, MAINS_HZ);
   localparam logic [IST_TIMER_W-1:0] LIM_V =
      ist_limit_cycles(VERT_MIN * IST_VERT_DS_PER_MIN, MAINS_HZ);
   localparam logic [IST_TIMER_W-1:0] LIM_V_T =
      ist_limit_cycles((VERT_MIN == 15) ? IST_VERT15_TEST_DS : IST_VERT_TEST_DS, MAINS_HZ);
   typedef struct packed {
      ist_state_t state;
      logic [2:0] tilt_sync;
      logic tilt_stable;
      logic tilt_primed;
      logic [19:0] deb_cnt;
      logic [2:0] mains_sync;
      logic mains_lvl;
      logic [2:0] test_sync;
      logic test_lvl;
      logic [2:0] dis_sync;
      logic dis_lvl;
      logic [IST_TIMER_W-1:0] pos_timer;
      logic [5:0] half_cnt;
      logic half_phase;
      logic [2:0] burst_cnt;
      logic [11:0] tone_cnt;
      logic tone;
      logic [1:0] ctrl;
      logic relay;
      logic led_oe;
      logic buz;
      logic awready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ist_regs_t;
   ist_regs_t r_reg;
   ist_regs_t r_next;
   logic mains_edge;
   logic moved;
   logic test_active;
   logic [IST_TIMER_W-1:0] cur_limit;
   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      r_next = r_reg;
      mains_edge = 1'b0;
      moved = 1'b0;
      // three-stage synchronisers; only stages two and three are examined
      r_next.tilt_sync = {r_reg.tilt_sync[1:0], tilt_sensor_in};
      r_next.mains_sync = {r_reg.mains_sync[1:0], mains_timebase_in};
      r_next.test_sync = {r_reg.test_sync[1:0], test_n_in};
      r_next.dis_sync = {r_reg.dis_sync[1:0], discharge_req_in};
      if (r_reg.mains_sync[1] == r_reg.mains_sync[2])
      begin
         r_next.mains_lvl = r_reg.mains_sync[2];
         mains_edge = r_reg.mains_sync[2] & ~r_reg.mains_lvl;
      end
      if (r_reg.test_sync[1] == r_reg.test_sync[2])
         r_next.test_lvl = r_reg.test_sync[2];
      if (r_reg.dis_sync[1] == r_reg.dis_sync[2])
         r_next.dis_lvl = r_reg.dis_sync[2];
      test_active = ~r_reg.test_lvl | r_reg.ctrl[IST_CTRL_TEST_BIT];
      // high level means horizontal; each position has its own limit
      if (r_reg.tilt_stable)
         cur_limit = test_active ? LIM_H_T : LIM_H;
      else
         cur_limit = test_active ? LIM_V_T : LIM_V;
      // a level must hold for the whole debounce span, else the count restarts
      if (r_reg.tilt_sync[1] == r_reg.tilt_sync[2] && r_reg.tilt_sync[2] != r_reg.tilt_stable)
      begin
         if (r_reg.deb_cnt == 20'(DEBOUNCE_CYC - 1))
         begin
            r_next.deb_cnt = 20'h0;
            r_next.tilt_stable = r_reg.tilt_sync[2];
            moved = r_reg.tilt_primed;
         end
         else
            r_next.deb_cnt = r_reg.deb_cnt + 20'h1;
      end
      else
      begin
         r_next.deb_cnt = 20'h0;
         // a quiet span after reset primes the filter so the resting level is no movement
         if (!r_reg.tilt_primed && r_reg.tilt_sync[1] == r_reg.tilt_sync[2])
         begin
            r_next.deb_cnt = r_reg.deb_cnt + 20'h1;
            r_next.tilt_primed = (r_reg.deb_cnt == 20'(DEBOUNCE_CYC - 1));
         end
      end
      // tone divider runs freely from the core clock
      if (r_reg.tone_cnt == 12'(IST_TONE_HALF_CYC - 1))
      begin
         r_next.tone_cnt = 12'h0;
         r_next.tone = ~r_reg.tone;
      end
      else
         r_next.tone_cnt = r_reg.tone_cnt + 12'h1;
      // position state machine
      case (r_reg.state)
         IST_ST_WAIT:
         begin
            if (moved)
            begin
               r_next.state = IST_ST_HEAT;
               r_next.pos_timer = '0;
            end
         end
         IST_ST_HEAT:
         begin
            if (moved)
               r_next.pos_timer = '0;
            else if (mains_edge)
            begin
               if (r_reg.pos_timer + 1'b1 >= cur_limit)
               begin
                  r_next.state = IST_ST_TOUT;
                  r_next.half_cnt = 6'h0;
                  r_next.half_phase = 1'b0;
                  r_next.burst_cnt = 3'h0;
               end
               r_next.pos_timer = r_reg.pos_timer + 1'b1;
            end
         end
         IST_ST_TOUT:
         begin
            if (moved)
            begin
               r_next.state = IST_ST_HEAT;
               r_next.pos_timer = '0;
               r_next.half_phase = 1'b0;
            end
            else if (mains_edge)
            begin
               // half-second phases from mains cycles give the flash and the bursts
               if (r_reg.half_cnt == 6'(HALF_SEC - 1))
               begin
                  r_next.half_cnt = 6'h0;
                  r_next.half_phase = ~r_reg.half_phase;
                  if (!r_reg.half_phase && r_reg.burst_cnt != 3'(IST_BURST_COUNT))
                     r_next.burst_cnt = r_reg.burst_cnt + 3'h1;
               end
               else
                  r_next.half_cnt = r_reg.half_cnt + 6'h1;
            end
         end
         default:
            r_next.state = IST_ST_WAIT;
      endcase
      // outputs follow the next state so they switch with it
      r_next.relay = (r_next.state == IST_ST_HEAT);
      r_next.led_oe = (r_next.state == IST_ST_TOUT) & r_next.half_phase;
      if (r_next.state == IST_ST_TOUT && !r_next.half_phase && !r_reg.ctrl[IST_CTRL_MUTE_BIT]
          && (BUZZ_CONTINUAL || r_next.burst_cnt != 3'(IST_BURST_COUNT)))
         r_next.buz = r_next.tone;
      else if (r_next.state == IST_ST_TOUT)
         r_next.buz = 1'b0;
      else
         r_next.buz = r_next.dis_lvl;
      // axi write: wait for address and data together, answer one cycle later
      r_next.awready = 1'b0;
      if (r_reg.bvalid && s_axi_bready)
         r_next.bvalid = 1'b0;
      if (r_reg.awready)
      begin
         r_next.bvalid = 1'b1;
         r_next.bresp = IST_RESP_SLVERR;
         if (s_axi_awaddr == IST_OFS_CTRL)
         begin
            r_next.bresp = IST_RESP_OKAY;
            if (s_axi_wstrb[0])
               r_next.ctrl = s_axi_wdata[1:0];
         end
         else if (s_axi_awaddr == IST_OFS_STATUS)
            r_next.bresp = IST_RESP_OKAY;
      end
      else if (s_axi_awvalid && s_axi_wvalid && !r_reg.bvalid)
         r_next.awready = 1'b1;
      // axi read
      r_next.arready = 1'b0;
      if (r_reg.rvalid && s_axi_rready)
         r_next.rvalid = 1'b0;
      if (r_reg.arready)
      begin
         r_next.rvalid = 1'b1;
         r_next.rresp = IST_RESP_OKAY;
         r_next.rdata = 32'h0;
         if (s_axi_araddr == IST_OFS_CTRL)
            r_next.rdata[1:0] = r_reg.ctrl;
         else if (s_axi_araddr == IST_OFS_STATUS)
         begin
            r_next.rdata[IST_STAT_STATE_LSB +: 3] = r_reg.state;
            r_next.rdata[IST_STAT_HORIZ_BIT] = r_reg.tilt_stable;
            r_next.rdata[IST_STAT_TEST_BIT] = test_active;
            r_next.rdata[IST_STAT_RELAY_BIT] = r_reg.relay;
            r_next.rdata[IST_STAT_BURST_LSB +: 3] = r_reg.burst_cnt;
            r_next.rdata[IST_STAT_TIMER_LSB +: IST_TIMER_W] = r_reg.pos_timer;
         end
         else
            r_next.rresp = IST_RESP_SLVERR;
      end
      else if (s_axi_arvalid && !r_reg.rvalid)
         r_next.arready = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // state register; test level resets high so the part starts in normal timing
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         r_reg <= '0;
         r_reg.state <= IST_ST_WAIT;
         r_reg.test_sync <= 3'h7;
         r_reg.test_lvl <= 1'b1;
         r_reg.ctrl <= IST_CTRL_RESET;
      end
      else
         r_reg <= r_next;
   end
   assign relay_out = r_reg.relay;
   assign led_out = 1'b0; // open drain: only the enable moves
   assign led_oe = r_reg.led_oe;
   assign discharge_buzzer_out = r_reg.buz;
   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.awready; // both channels taken together
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_heat_then_tout;
      r_reg.state == IST_ST_HEAT ##1 r_reg.state == IST_ST_TOUT;
   endsequence
   property p_wait_dark;
      r_reg.state == IST_ST_WAIT |-> !relay_out && !led_oe;
   endproperty
   a_wait_dark: assert property (p_wait_dark) else $error("relay or led active before movement");
   property p_heat_relay;
      r_reg.state == IST_ST_HEAT |-> relay_out && !led_oe;
   endproperty
   a_heat_relay: assert property (p_heat_relay) else $error("heating without relay");
   property p_tout_limit;
      s_heat_then_tout |-> $past(r_reg.pos_timer) + 1'b1 >= $past(cur_limit)
                           && $past(r_reg.pos_timer) + 1'b1 == r_reg.pos_timer;
   endproperty
   a_tout_limit: assert property (p_tout_limit) else $error("timeout not at limit");
   property p_tout_relay;
      r_reg.state == IST_ST_TOUT |-> !relay_out;
   endproperty
   a_tout_relay: assert property (p_tout_relay) else $error("relay on after timeout");
   property p_debounce;
      $changed(r_reg.tilt_stable) |-> $past(r_reg.deb_cnt) == 20'(DEBOUNCE_CYC - 1);
   endproperty
   a_debounce: assert property (p_debounce) else $error("tilt accepted too early");
   property p_move_restart;
      moved ##1 1'b1 |-> r_reg.state == IST_ST_HEAT && r_reg.pos_timer == '0 ##1 relay_out;
   endproperty
   a_move_restart: assert property (p_move_restart) else $error("movement did not restart");
   property p_flash;
      $changed(r_reg.half_phase) && r_reg.state == IST_ST_TOUT
         |-> $past(r_reg.half_cnt) == 6'(HALF_SEC - 1);
   endproperty
   a_flash: assert property (p_flash) else $error("flash phase wrong length");
   property p_tone;
      $changed(r_reg.tone) |-> $past(r_reg.tone_cnt) == 12'(IST_TONE_HALF_CYC - 1);
   endproperty
   a_tone: assert property (p_tone) else $error("tone half period wrong");
   property p_burst_stop;
      !BUZZ_CONTINUAL && r_reg.state == IST_ST_TOUT && r_reg.burst_cnt == 3'(IST_BURST_COUNT)
         |-> !discharge_buzzer_out;
   endproperty
   a_burst_stop: assert property (p_burst_stop) else $error("buzzer after last burst");
   property p_discharge;
      r_reg.state != IST_ST_TOUT |-> discharge_buzzer_out == r_reg.dis_lvl;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge path broken");
endmodule : ist_timeout_ctrl
